/* src/readback_pkg.sv */
// Package: register indices, field positions and reset values
// Assumes one 125 MHz clock domain shared by every user
package readback_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 14;
    localparam int EVENT_W = 3;

    // Read indices
    localparam logic [3:0] IDX_SPECIAL_RX_STATUS = 4'h1;
    localparam logic [3:0] IDX_TX_CONFIG_READBACK = 4'h5;
    localparam logic [3:0] IDX_FRAME_BYTE_COUNT_LOW = 4'h6;
    localparam logic [3:0] IDX_FRAME_BYTE_COUNT_HIGH = 4'h7;
    localparam logic [3:0] IDX_EVENT_STATUS = 4'hc;
    localparam logic [3:0] IDX_EVENT_ENABLE = 4'he;
    // Write indices
    localparam logic [3:0] IDX_EXTENDED_CONTROL_PRIME = 4'h7;
    localparam logic [3:0] IDX_EVENT_CLEAR = 4'hd;
    localparam logic [3:0] IDX_EXTENDED_FEATURE_CONTROL = 4'hf;

    // Field positions
    localparam int PRIME_ALIAS_BIT = 6;
    localparam int FEATURE_COUNT_BIT = 2;
    localparam int HIGH_OVERFLOW_BIT = 7;
    localparam int HIGH_SOURCE_BIT = 6;

    // Character length codes
    localparam logic [1:0] CHAR_LEN_5 = 2'h0;
    localparam logic [1:0] CHAR_LEN_7 = 2'h1;
    localparam logic [1:0] CHAR_LEN_6 = 2'h2;
    localparam logic [1:0] CHAR_LEN_8 = 2'h3;

    // Event bits
    localparam int EV_OVERFLOW = 0;
    localparam int EV_FRAME_DONE = 1;
    localparam int EV_DATA_AVAIL = 2;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [EVENT_W-1:0] EVENT_RESET = 3'h0;
endpackage

/* src/event_if.sv */
// Interface: event set, clear and enable lines between bank and flags
// Assumes both ends run on the same clock
interface event_if;
    import readback_pkg::*;
    logic [EVENT_W-1:0] set;
    logic [EVENT_W-1:0] clear;
    logic [EVENT_W-1:0] enable;
    logic [EVENT_W-1:0] status;
    logic irq;
    modport bank (output set, output clear, output enable,
                  input status, input irq);
    modport flags (input set, input clear, input enable,
                   output status, output irq);
endinterface

/* src/event_flags.sv */
// Sticky event flags with mask and one level interrupt
// Assumes set and clear are one-cycle pulses on the same clock
module event_flags (
    input wire logic clk_i,
    input wire logic arst_n_i,
    event_if.flags ev
);
    import readback_pkg::*;

    typedef struct packed {
        logic [EVENT_W-1:0] status;
    } flags_state_t;

    flags_state_t state_reg;
    flags_state_t state_next;

    always_comb begin
        state_next = state_reg;
        // Set wins so an event in the clear cycle is kept
        state_next.status = (state_reg.status & ~ev.clear) | ev.set;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg.status <= EVENT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ev.status = state_reg.status;
    assign ev.irq = |(state_reg.status & ev.enable);
endmodule

/* src/serial_channel_status_readback.sv */
// Readback bank of one serial channel: transmit config, frame count
// Assumes channel inputs come from logic on clk_i, so none are synced
// Assumes host strobes last one cycle and never overlap
// Behaviour
// - Transmit config readback carries character length in bits 6:5 as 00 five or less, 01 seven, 10 six, 11 eight.
// - Frame byte count low returns count bits 7:0 only when extended feature bit 2 is 1, else the interrupt vector.
// - Frame byte count high returns count bits 13:8 in bits 5:0 only when extended feature bit 2 is 1, else pending flags.
// - Bit 7 of the high count register reads 0 after status FIFO overflow and 1 in normal operation.
// - All three readback registers are read only and hold no defined value until configured or a frame is counted.
//
// The plain strobed port and the placing of the registers were decided locally.
module serial_channel_status_readback (
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [readback_pkg::ADDR_W-1:0] addr_i,
    input wire logic [readback_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [readback_pkg::DATA_W-1:0] rdata_o,
    // Transmit configuration from the channel
    input wire logic dtr_i,
    input wire logic [1:0] tx_char_len_i,
    input wire logic send_break_i,
    input wire logic tx_enable_i,
    input wire logic crc16_select_i,
    input wire logic rts_i,
    input wire logic tx_crc_enable_i,
    // Frame status from the channel
    input wire logic [readback_pkg::COUNT_W-1:0] frame_byte_count_i,
    input wire logic frame_done_i,
    input wire logic status_fifo_overflow_i,
    input wire logic status_fifo_data_available_i,
    // Other read registers that share indices
    input wire logic [readback_pkg::DATA_W-1:0] special_rx_status_i,
    input wire logic [readback_pkg::DATA_W-1:0] interrupt_vector_readback_i,
    input wire logic [readback_pkg::DATA_W-1:0] pending_interrupt_flags_i,
    // Control state seen by the rest of the channel
    output logic [readback_pkg::DATA_W-1:0] extended_control_prime_o,
    output logic [readback_pkg::DATA_W-1:0] extended_feature_control_o,
    output logic irq_o
);
    import readback_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] prime;
        logic [DATA_W-1:0] feature;
        logic [EVENT_W-1:0] enable;
        logic [DATA_W-1:0] rdata;
        logic overflow_seen;
        logic avail_seen;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;
    event_if ev ();
    logic [DATA_W-1:0] tx_config;
    logic [DATA_W-1:0] count_low;
    logic [DATA_W-1:0] count_high;
    logic [EVENT_W-1:0] clear_pulse;

    // Read path
    logic alias_rx_status;
    logic count_visible;
    logic [DATA_W-1:0] tx_view;
    logic [DATA_W-1:0] low_view;
    logic [DATA_W-1:0] high_view;
    logic [DATA_W-1:0] read_value;

    // Write decode
    logic wr_prime;
    logic wr_feature;
    logic wr_enable;
    logic wr_clear;

    // Event edges
    logic overflow_rise;
    logic avail_rise;

    // Pure mirrors: no storage, so contents follow the channel
    assign tx_config = {
        dtr_i,
        tx_char_len_i,
        send_break_i,
        tx_enable_i,
        crc16_select_i,
        rts_i,
        tx_crc_enable_i
    };
    assign count_low = frame_byte_count_i[DATA_W-1:0];
    assign count_high = {
        ~status_fifo_overflow_i,
        ~status_fifo_data_available_i,
        frame_byte_count_i[COUNT_W-1:DATA_W]
    };

    // Selects come from registered control, so a write lands first
    assign alias_rx_status = state_reg.prime[PRIME_ALIAS_BIT];
    assign count_visible = state_reg.feature[FEATURE_COUNT_BIT];

    // Index 7 is shared: a write there is prime, a read is count high
    assign wr_prime = wr_i && (addr_i == IDX_EXTENDED_CONTROL_PRIME);
    assign wr_feature = wr_i && (addr_i == IDX_EXTENDED_FEATURE_CONTROL);
    assign wr_enable = wr_i && (addr_i == IDX_EVENT_ENABLE);
    assign wr_clear = wr_i && (addr_i == IDX_EVENT_CLEAR);

    // Index 5 view: alias follows the registered prime bit
    always_comb begin
        if (alias_rx_status) begin
            tx_view = special_rx_status_i;
        end else begin
            tx_view = tx_config;
        end
    end

    // Count hidden unless enabled, as the vector shares the index
    always_comb begin
        if (count_visible) begin
            low_view = count_low;
        end else begin
            low_view = interrupt_vector_readback_i;
        end
    end

    // Low and high are not latched together: each read samples live
    always_comb begin
        if (count_visible) begin
            high_view = count_high;
        end else begin
            high_view = pending_interrupt_flags_i;
        end
    end

    // Unmapped indices read as zero
    always_comb begin
        read_value = '0;
        case (addr_i)
            IDX_TX_CONFIG_READBACK: begin
                read_value = tx_view;
            end
            IDX_FRAME_BYTE_COUNT_LOW: begin
                read_value = low_view;
            end
            IDX_FRAME_BYTE_COUNT_HIGH: begin
                read_value = high_view;
            end
            IDX_EVENT_STATUS: begin
                read_value = {5'h00, ev.status};
            end
            IDX_EVENT_ENABLE: begin
                read_value = {5'h00, state_reg.enable};
            end
            default: begin
                read_value = '0;
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        clear_pulse = '0;
        // Edge history follows the levels every cycle
        state_next.overflow_seen = status_fifo_overflow_i;
        state_next.avail_seen = status_fifo_data_available_i;
        // Host never strobes both at once, so no priority is needed
        if (wr_prime) begin
            state_next.prime = wdata_i;
        end
        if (wr_feature) begin
            state_next.feature = wdata_i;
        end
        if (wr_enable) begin
            state_next.enable = wdata_i[EVENT_W-1:0];
        end
        if (wr_clear) begin
            clear_pulse = wdata_i[EVENT_W-1:0];
        end
        // Read data valid only in the cycle after the strobe
        if (rd_i) begin
            state_next.rdata = read_value;
        end else begin
            state_next.rdata = '0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg.prime <= CONTROL_RESET;
            state_reg.feature <= CONTROL_RESET;
            state_reg.enable <= EVENT_RESET;
            state_reg.rdata <= 8'h00;
            state_reg.overflow_seen <= 1'b0;
            state_reg.avail_seen <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Edges, so a stuck level raises one event and not a storm
    assign overflow_rise = status_fifo_overflow_i & ~state_reg.overflow_seen;
    assign avail_rise = status_fifo_data_available_i & ~state_reg.avail_seen;

    // Frame done is already a one-cycle pulse, so it takes no edge
    always_comb begin
        ev.set = '0;
        ev.set[EV_OVERFLOW] = overflow_rise;
        ev.set[EV_FRAME_DONE] = frame_done_i;
        ev.set[EV_DATA_AVAIL] = avail_rise;
    end
    assign ev.clear = clear_pulse;
    assign ev.enable = state_reg.enable;

    // Sticky status, mask and interrupt level live in the flags module
    event_flags event_flags_inst (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ev(ev)
    );

    assign rdata_o = state_reg.rdata;
    assign extended_control_prime_o = state_reg.prime;
    assign extended_feature_control_o = state_reg.feature;
    assign irq_o = ev.irq;
endmodule

/* bench/readback_checker.sv */
// Checker: read mux and control writes of the readback bank
// Assumes one clock; sees only the bank's ports
module readback_checker (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] tx_char_len_i,
    input wire logic [13:0] frame_byte_count_i,
    input wire logic status_fifo_overflow_i,
    input wire logic status_fifo_data_available_i,
    input wire logic [7:0] special_rx_status_i,
    input wire logic [7:0] interrupt_vector_readback_i,
    input wire logic [7:0] extended_control_prime_o,
    input wire logic [7:0] extended_feature_control_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic p5, p6, p7, fe;
    assign p5 = rd_i && addr_i == 4'h5;
    assign p6 = rd_i && addr_i == 4'h6;
    assign p7 = rd_i && addr_i == 4'h7;
    assign fe = extended_feature_control_o[2];
    a_len_code: assert property (p5 && !extended_control_prime_o[6] |=>
        rdata_o[6:5] == $past(tx_char_len_i)) else $error("char length");
    a_rx_alias: assert property (p5 && extended_control_prime_o[6] |=>
        rdata_o == $past(special_rx_status_i)) else $error("alias");
    a_count_low: assert property (p6 && fe |=>
        rdata_o == $past(frame_byte_count_i[7:0])) else $error("count low");
    a_vector_fallback: assert property (p6 && !fe |=>
        rdata_o == $past(interrupt_vector_readback_i)) else $error("vector");
    a_count_high: assert property (p7 && fe |=>
        rdata_o[5:0] == $past(frame_byte_count_i[13:8]))
        else $error("count hi");
    a_overflow_flag: assert property (p7 && fe |=>
        rdata_o[7] != $past(status_fifo_overflow_i)) else $error("overflow");
    a_fifo_source: assert property (p7 && fe |=>
        rdata_o[6] != $past(status_fifo_data_available_i)) else $error("src");
    a_read_only: assert property (wr_i && addr_i == 4'h5 |=>
        $stable(extended_control_prime_o)
        && $stable(extended_feature_control_o))
        else $error("read-only write changed control");
endmodule
bind serial_channel_status_readback readback_checker readback_checker_inst (
    .clk_i, .arst_n_i, .addr_i, .wr_i, .rd_i, .rdata_o, .tx_char_len_i,
    .frame_byte_count_i, .status_fifo_overflow_i, .special_rx_status_i,
    .status_fifo_data_available_i, .interrupt_vector_readback_i,
    .extended_control_prime_o, .extended_feature_control_o);

/* bench/host_model.sv */
// Host model: register port master with one-cycle strobes
// Assumes the bench calls one task at a time; no wait states
module host_model (
    input wire logic clk_i,
    output logic [3:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // Idle bus shows inverted values so stale data cannot pass
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
        @(posedge clk_i);
        {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge clk_i);
        {addr_o, rd_o} <= {a, 1'b1};
        @(posedge clk_i);
        {addr_o, rd_o} <= {~a, 1'b0};
    endtask
endmodule

/* bench/test_serial_channel_status_readback.sv */
// Testbench: register reads and writes, event flags of the bank
// Assumes host_model owns the register port
module test_serial_channel_status_readback;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, arst_n_i = 1'b0, rd_d = 1'b0;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, r, ecp, efc, sts, en;
    logic wr_i, rd_i, frame_done_i, irq_o, dtr_i, send_break_i, tx_enable_i;
    logic crc16_select_i, rts_i, tx_crc_enable_i;
    logic status_fifo_overflow_i, status_fifo_data_available_i;
    logic [1:0] tx_char_len_i;
    logic [13:0] frame_byte_count_i;
    logic [7:0] special_rx_status_i, interrupt_vector_readback_i;
    logic [7:0] pending_interrupt_flags_i, extended_control_prime_o;
    logic [7:0] extended_feature_control_o;
    logic [7:0] q[$];
    int err_count = 0, num_checks = 0, cycles = 0, seed = 64;
    always #4 clk_i = ~clk_i;
    host_model host_model_inst (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i));
    serial_channel_status_readback serial_channel_status_readback_inst (
        .clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .dtr_i,
        .tx_char_len_i, .send_break_i, .tx_enable_i, .crc16_select_i, .rts_i,
        .tx_crc_enable_i, .frame_byte_count_i, .frame_done_i,
        .status_fifo_overflow_i, .status_fifo_data_available_i,
        .special_rx_status_i, .interrupt_vector_readback_i,
        .pending_interrupt_flags_i, .extended_control_prime_o,
        .extended_feature_control_o, .irq_o);
    task end_of_test;
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function logic [7:0] exp_rd(input logic [3:0] a);
        case (a)
            4'h5: return ecp[6] ? special_rx_status_i : {dtr_i, tx_char_len_i,
                send_break_i, tx_enable_i, crc16_select_i, rts_i,
                tx_crc_enable_i};
            4'h6: return efc[2] ? frame_byte_count_i[7:0]
                : interrupt_vector_readback_i;
            4'h7: return efc[2] ? {~status_fifo_overflow_i,
                ~status_fifo_data_available_i, frame_byte_count_i[13:8]}
                : pending_interrupt_flags_i;
            4'hc: return sts;
            4'he: return en;
            default: return 8'h00;
        endcase
    endfunction
    task rd(input logic [3:0] a);
        q.push_back(exp_rd(a));
        host_model_inst.rd_reg(a);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        if (a == 4'h7) ecp = d;
        if (a == 4'hf) efc = d;
        if (a == 4'he) en = d & 8'h07;
        if (a == 4'hd) sts = sts & ~d;
        host_model_inst.wr_reg(a, d);
    endtask
    task pulse_frame;
        @(posedge clk_i) frame_done_i <= 1'b1;
        @(posedge clk_i) frame_done_i <= 1'b0;
        sts[1] = 1'b1;
        @(negedge clk_i);
    endtask
    task rnd(input logic [1:0] l);
        @(posedge clk_i);
        r = 8'($random(seed));
        // Rising status levels raise sticky events one edge later
        if (r[6] && !status_fifo_overflow_i) sts[0] = 1'b1;
        if (r[5] && !status_fifo_data_available_i) sts[2] = 1'b1;
        {dtr_i, tx_char_len_i, send_break_i, tx_enable_i} <= {r[7], l, r[4:3]};
        {crc16_select_i, rts_i, tx_crc_enable_i} <= r[2:0];
        frame_byte_count_i <= 14'($random(seed));
        {status_fifo_overflow_i, status_fifo_data_available_i} <= r[6:5];
        special_rx_status_i <= 8'($random(seed));
        interrupt_vector_readback_i <= 8'($random(seed));
        pending_interrupt_flags_i <= 8'($random(seed));
        @(negedge clk_i);
    endtask
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d) check(rdata_o, q.pop_front());
    end
    always @(posedge clk_i) if (++cycles == 3000) begin
        err_count++;
        end_of_test;
    end
    initial begin
        {ecp, efc, sts, en, frame_done_i} = '0;
        {status_fifo_overflow_i, status_fifo_data_available_i} = 2'b00;
        rnd(2'h0);
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        wr(4'he, 8'h07);
        pulse_frame;
        check({7'h0, irq_o}, 8'h01);
        rd(4'hc);
        rd(4'he);
        wr(4'hd, 8'h02);
        @(negedge clk_i) check({7'h0, irq_o}, {7'h0, |(sts[2:0] & en[2:0])});
        wr(4'he, 8'h00);
        pulse_frame;
        check({7'h0, irq_o}, 8'h00);
        rd(4'hc);
        wr(4'hd, 8'hff);
        for (int i = 0; i < 16; i++) begin
            rnd(i[1:0]);
            wr(4'h7, {1'b0, i[2], 6'h15});
            wr(4'hf, {5'h0, i[3], 2'h1});
            wr(4'h5, 8'hff);
            rd(4'h5);
            rd(4'h6);
            rd(4'h7);
            rd(4'h3);
            check(extended_feature_control_o, efc);
            check(extended_control_prime_o, ecp);
        end
        repeat (3) @(posedge clk_i);
        end_of_test;
    end
endmodule
